// ===== src/cfs_pkg.sv
// constants, field positions and carrier types of the machine state block
// Contract
// - four registers split into word and byte halves
// - instruction pointer drives fetch, advances per instruction
// - low sixteen flag bits form legacy flags
// - carry flag tracks carry or borrow out
// - parity flag set on even low byte ones
// - aux carry tracks low nibble carry or borrow
// - zero flag set on zero result
// - sign flag copies result top bit
// - overflow flag when carries into/out of sign differ
// - single step traps after next instruction, clears
// - maskable interrupts taken only with enable set
// - direction flag picks index increment or decrement
// - io privilege gates io and enable changes; the code gates enable changes in virtual mode only
// - nested task flag marks nested task
// - resume flag suppresses debug fault next instruction
// - virtual mode flag faults privileged opcodes
// - protection enable set by both loads, cleared by one
// - monitor bit lets wait raise extension fault
// - emulate bit faults every escape instruction
// - task switched bit faults next extension use
// - paging bit turns paging unit on/off
// - multi-byte operands stored low byte first
package cfs_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  localparam int CFS_ADDR_W = 8;
  localparam logic [7:0] CFS_OFF_FLAGS = 8'h00;
  localparam logic [7:0] CFS_OFF_CTRL = 8'h04;
  localparam logic [7:0] CFS_OFF_MSW = 8'h08;
  localparam logic [7:0] CFS_OFF_IP = 8'h0C;
  localparam logic [7:0] CFS_OFF_STATE = 8'h10;
  localparam logic [2:0] CFS_GPR_PAGE = 3'h1;
  ////////////////////////////////////////////////////////////////////////////////
  localparam int CFS_CF = 0;
  localparam int CFS_PF = 2;
  localparam int CFS_AF = 4;
  localparam int CFS_ZF = 6;
  localparam int CFS_SF = 7;
  localparam int CFS_TF = 8;
  localparam int CFS_IF = 9;
  localparam int CFS_DF = 10;
  localparam int CFS_OF = 11;
  localparam int CFS_IO_PRIVILEGE_FIELD_LO = 12;
  localparam int CFS_NT = 14;
  localparam int CFS_RF = 16;
  localparam int CFS_VM = 17;
  localparam int CFS_PE = 0;
  localparam int CFS_MP = 1;
  localparam int CFS_EM = 2;
  localparam int CFS_TS = 3;
  localparam int CFS_PG = 31;
  localparam logic [31:0] CFS_FLAGS_WMASK = 32'h0003_7FD5;
  localparam logic [31:0] CFS_FLAGS_RESET = 32'h0000_0002;
  localparam logic [31:0] CFS_CTRL_WMASK = 32'h8000_000F;
  localparam logic [31:0] CFS_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CFS_MSW_WMASK = 32'h0000_000F;
  localparam logic [31:0] CFS_GPR_RESET = 32'h0000_0000;
  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    CFS_SZ_BYTE = 2'b00,
    CFS_SZ_WORD = 2'b01,
    CFS_SZ_DWORD = 2'b10
  } cfs_size_type;
  typedef enum logic [1:0] {
    CFS_V_DWORD = 2'b00,
    CFS_V_WORD = 2'b01,
    CFS_V_BYTE_LO = 2'b10,
    CFS_V_BYTE_HI = 2'b11
  } cfs_view_type;
  typedef struct packed {
    logic valid;
    logic sub;
    cfs_size_type size;
    logic [31:0] a;
    logic [31:0] b;
  } cfs_alu_type;
  typedef struct packed {
    logic we;
    logic [2:0] idx;
    cfs_view_type view;
    logic [31:0] data;
  } cfs_gpr_type;
  typedef struct packed {
    logic valid;
    cfs_size_type size;
    logic [31:0] addr;
    logic [31:0] data;
  } cfs_store_type;
endpackage

// ===== src/cfs_machine_state.sv
// architectural machine state: flags, control word, pointer, general registers
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module cfs_machine_state
  import cfs_pkg::*;
#(
  parameter logic [31:0] IP_RESET = 32'h0000_0000
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [CFS_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // execution datapath requests
  input wire cfs_alu_type alu_in,
  input wire cfs_gpr_type gpr_wr_in,
  input wire logic [2:0] gpr_rd_idx_in,
  input wire cfs_view_type gpr_rd_view_in,
  input wire cfs_store_type store_in,
  // instruction boundary events
  input wire logic retire_in,
  input wire logic [3:0] retire_len_in,
  input wire logic branch_in,
  input wire logic [31:0] branch_target_in,
  input wire logic intr_in,
  input wire logic debug_hit_in,
  input wire logic [1:0] cpl_in,
  input wire logic io_op_in,
  input wire logic if_change_in,
  input wire logic priv_op_in,
  input wire logic wait_op_in,
  input wire logic esc_op_in,
  input wire logic str_step_in,
  input wire cfs_size_type str_size_in,
  // state and decisions
  output logic [31:0] fetch_addr_out,
  output logic [31:0] gpr_rd_data_out,
  output logic [31:0] flags_out,
  output logic [15:0] legacy_flags_out,
  output logic protected_mode_out,
  output logic paging_on_out,
  output logic v86_mode_out,
  output logic nested_task_out,
  output logic int_take_out,
  output logic step_trap_out,
  output logic debug_fault_out,
  output logic exc7_out,
  output logic exc13_out,
  output logic io_direct_ok_out,
  output logic if_change_ok_out,
  output logic [31:0] str_delta_out,
  output logic [31:0] mem_addr_out,
  output logic [3:0] mem_byte_en_out,
  output logic [31:0] mem_data_out
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] flags_r;
  logic [31:0] ctrl_r;
  logic [31:0] ip_r;
  logic [31:0] gpr_r [8];
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] gpr_rd_r;
  logic int_take_r;
  logic step_trap_r;
  logic debug_fault_r;
  logic exc7_r;
  logic exc13_r;
  logic io_ok_r;
  logic if_ok_r;
  logic v86_r;
  logic [31:0] str_delta_r;
  logic [31:0] mem_addr_r;
  logic [3:0] mem_be_r;
  logic [31:0] mem_data_r;

  logic wr_en;
  logic rd_setup;
  logic hit_gpr;
  logic [2:0] bus_idx;
  logic pe_w;
  logic vm_w;
  logic [1:0] io_privilege_field_w;

  assign wr_en = psel_in && penable_in && pwrite_in && pready_r;
  assign rd_setup = psel_in && !penable_in;
  assign hit_gpr = (paddr_in[7:5] == CFS_GPR_PAGE) && (paddr_in[1:0] == 2'b00);
  assign bus_idx = paddr_in[4:2];
  assign pe_w = ctrl_r[CFS_PE];
  assign vm_w = flags_r[CFS_VM] && pe_w;
  assign io_privilege_field_w = flags_r[CFS_IO_PRIVILEGE_FIELD_LO+1:CFS_IO_PRIVILEGE_FIELD_LO];

  ////////////////////////////////////////////////////////////////////////////////
  // alu flag results; operands are masked to size so bit msb+1 is carry or borrow
  logic [31:0] size_mask;
  logic [4:0] msb;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [32:0] sum;
  logic [31:0] res;
  logic [31:0] carry_vec;
  logic res_cf;
  logic res_of;

  always_comb begin
    case (alu_in.size)
      CFS_SZ_BYTE: begin
        size_mask = 32'h0000_00FF;
        msb = 5'd7;
      end
      CFS_SZ_WORD: begin
        size_mask = 32'h0000_FFFF;
        msb = 5'd15;
      end
      default: begin
        size_mask = 32'hFFFF_FFFF;
        msb = 5'd31;
      end
    endcase
    op_a = alu_in.a & size_mask;
    op_b = alu_in.b & size_mask;
    if (alu_in.sub) begin
      sum = {1'b0, op_a} - {1'b0, op_b};
    end else begin
      sum = {1'b0, op_a} + {1'b0, op_b};
    end
    res = sum[31:0] & size_mask;
    carry_vec = op_a ^ op_b ^ sum[31:0];
    res_cf = sum[{1'b0, msb} + 6'd1];
    res_of = carry_vec[msb] ^ res_cf;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flags register; software write lands last so a set from software wins
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      flags_r <= CFS_FLAGS_RESET;
    end else begin
      if (alu_in.valid) begin
        flags_r[CFS_CF] <= res_cf;
        flags_r[CFS_PF] <= ~^res[7:0];
        flags_r[CFS_AF] <= carry_vec[4];
        flags_r[CFS_ZF] <= (res == 32'h0000_0000);
        flags_r[CFS_SF] <= res[msb];
        flags_r[CFS_OF] <= res_of;
      end
      if (retire_in) begin
        flags_r[CFS_TF] <= 1'b0;
        flags_r[CFS_RF] <= 1'b0;
      end
      if (wr_en && paddr_in == CFS_OFF_FLAGS) begin
        flags_r <= (pwdata_in & CFS_FLAGS_WMASK) | CFS_FLAGS_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control word; status word load can only raise protection enable
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ctrl_r <= CFS_CTRL_RESET;
    end else if (wr_en && paddr_in == CFS_OFF_CTRL) begin
      ctrl_r <= pwdata_in & CFS_CTRL_WMASK;
    end else if (wr_en && paddr_in == CFS_OFF_MSW) begin
      ctrl_r[CFS_TS:CFS_MP] <= pwdata_in[CFS_TS:CFS_MP];
      ctrl_r[CFS_PE] <= ctrl_r[CFS_PE] | pwdata_in[CFS_PE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // instruction pointer
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ip_r <= IP_RESET;
    end else if (wr_en && paddr_in == CFS_OFF_IP) begin
      ip_r <= pwdata_in;
    end else if (retire_in && branch_in) begin
      ip_r <= branch_target_in;
    end else if (retire_in) begin
      ip_r <= ip_r + {28'h000_0000, retire_len_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // general registers; byte halves exist only for the first four
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 8; i++) begin
        gpr_r[i] <= CFS_GPR_RESET;
      end
    end else begin
      if (gpr_wr_in.we) begin
        case (gpr_wr_in.view)
          CFS_V_DWORD: gpr_r[gpr_wr_in.idx] <= gpr_wr_in.data;
          CFS_V_WORD: gpr_r[gpr_wr_in.idx][15:0] <= gpr_wr_in.data[15:0];
          CFS_V_BYTE_LO: begin
            if (!gpr_wr_in.idx[2]) begin
              gpr_r[gpr_wr_in.idx][7:0] <= gpr_wr_in.data[7:0];
            end
          end
          default: begin
            if (!gpr_wr_in.idx[2]) begin
              gpr_r[gpr_wr_in.idx][15:8] <= gpr_wr_in.data[7:0];
            end
          end
        endcase
      end
      if (wr_en && hit_gpr) begin
        gpr_r[bus_idx] <= pwdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      gpr_rd_r <= 32'h0000_0000;
    end else begin
      case (gpr_rd_view_in)
        CFS_V_DWORD: gpr_rd_r <= gpr_r[gpr_rd_idx_in];
        CFS_V_WORD: gpr_rd_r <= {16'h0000, gpr_r[gpr_rd_idx_in][15:0]};
        CFS_V_BYTE_LO: gpr_rd_r <= gpr_rd_idx_in[2] ? 32'h0000_0000 :
                                   {24'h00_0000, gpr_r[gpr_rd_idx_in][7:0]};
        default: gpr_rd_r <= gpr_rd_idx_in[2] ? 32'h0000_0000 :
                             {24'h00_0000, gpr_r[gpr_rd_idx_in][15:8]};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access phase, read data fetched in setup
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= rd_setup;
      pslverr_r <= 1'b0;
      if (rd_setup) begin
        prdata_r <= 32'h0000_0000;
        if (paddr_in == CFS_OFF_FLAGS) begin
          prdata_r <= flags_r;
        end else if (paddr_in == CFS_OFF_CTRL || paddr_in == CFS_OFF_MSW) begin
          prdata_r <= ctrl_r;
        end else if (paddr_in == CFS_OFF_IP) begin
          prdata_r <= ip_r;
        end else if (paddr_in == CFS_OFF_STATE) begin
          prdata_r <= {28'h000_0000, nested_task_out, v86_mode_out, paging_on_out,
                       protected_mode_out};
        end else if (hit_gpr) begin
          prdata_r <= gpr_r[bus_idx];
        end else begin
          pslverr_r <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // boundary decisions, all one cycle after the event
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      int_take_r <= 1'b0;
      step_trap_r <= 1'b0;
      debug_fault_r <= 1'b0;
    end else begin
      int_take_r <= retire_in && intr_in && flags_r[CFS_IF];
      step_trap_r <= retire_in && flags_r[CFS_TF];
      debug_fault_r <= retire_in && debug_hit_in && !flags_r[CFS_RF];
    end
  end

  // exception 7 from extension bits, exception 13 from virtual mode privileged opcodes
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      exc7_r <= 1'b0;
      exc13_r <= 1'b0;
      io_ok_r <= 1'b1;
      if_ok_r <= 1'b1;
      v86_r <= 1'b0;
    end else begin
      exc7_r <= (esc_op_in && (ctrl_r[CFS_EM] || ctrl_r[CFS_TS])) ||
                (wait_op_in && ctrl_r[CFS_MP] && ctrl_r[CFS_TS]);
      exc13_r <= vm_w && priv_op_in;
      io_ok_r <= !pe_w || (!vm_w && cpl_in <= io_privilege_field_w);
      if_ok_r <= !vm_w || (cpl_in <= io_privilege_field_w);
      v86_r <= vm_w;
    end
  end

  // string index step; decrement is the two's complement of the size
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      str_delta_r <= 32'h0000_0000;
    end else if (str_step_in) begin
      case (str_size_in)
        CFS_SZ_BYTE: str_delta_r <= flags_r[CFS_DF] ? 32'hFFFF_FFFF : 32'h0000_0001;
        CFS_SZ_WORD: str_delta_r <= flags_r[CFS_DF] ? 32'hFFFF_FFFE : 32'h0000_0002;
        default: str_delta_r <= flags_r[CFS_DF] ? 32'hFFFF_FFFC : 32'h0000_0004;
      endcase
    end
  end

  // lane i holds the byte at operand address plus i
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      mem_addr_r <= 32'h0000_0000;
      mem_be_r <= 4'h0;
      mem_data_r <= 32'h0000_0000;
    end else begin
      mem_addr_r <= store_in.addr;
      mem_data_r <= store_in.data;
      if (!store_in.valid) begin
        mem_be_r <= 4'h0;
      end else if (store_in.size == CFS_SZ_BYTE) begin
        mem_be_r <= 4'h1;
      end else if (store_in.size == CFS_SZ_WORD) begin
        mem_be_r <= 4'h3;
      end else begin
        mem_be_r <= 4'hF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign fetch_addr_out = ip_r;
  assign gpr_rd_data_out = gpr_rd_r;
  assign flags_out = flags_r;
  assign legacy_flags_out = flags_r[15:0];
  assign protected_mode_out = ctrl_r[CFS_PE];
  assign paging_on_out = ctrl_r[CFS_PG];
  assign v86_mode_out = v86_r;
  assign nested_task_out = flags_r[CFS_NT];
  assign int_take_out = int_take_r;
  assign step_trap_out = step_trap_r;
  assign debug_fault_out = debug_fault_r;
  assign exc7_out = exc7_r;
  assign exc13_out = exc13_r;
  assign io_direct_ok_out = io_ok_r;
  assign if_change_ok_out = if_ok_r;
  assign str_delta_out = str_delta_r;
  assign mem_addr_out = mem_addr_r;
  assign mem_byte_en_out = mem_be_r;
  assign mem_data_out = mem_data_r;

  ////////////////////////////////////////////////////////////////////////////////
  chk_ip_advance: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    retire_in && !branch_in && !(wr_en && paddr_in == CFS_OFF_IP)
    |=> fetch_addr_out == $past(ip_r) + {28'h000_0000, $past(retire_len_in)})
    else $error("pointer did not advance by instruction length");

  chk_zero_sign: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    alu_in.valid && !(wr_en && paddr_in == CFS_OFF_FLAGS)
    |=> flags_r[CFS_ZF] == ($past(res) == 32'h0000_0000) && flags_r[CFS_SF] == $past(res[msb]))
    else $error("zero or sign flag wrong");

  chk_parity_flag: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    alu_in.valid && !(wr_en && paddr_in == CFS_OFF_FLAGS)
    |=> flags_r[CFS_PF] == ~^$past(res[7:0]))
    else $error("parity flag wrong");

  chk_overflow_carry: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    alu_in.valid && !(wr_en && paddr_in == CFS_OFF_FLAGS)
    |=> flags_r[CFS_OF] == (flags_r[CFS_CF] ^ $past(carry_vec[msb])))
    else $error("overflow flag not carry-in xor carry-out");

  chk_step_trap: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    retire_in && flags_r[CFS_TF] && !wr_en |=> step_trap_out && !flags_r[CFS_TF])
    else $error("single step not taken or flag not cleared");

  chk_intr_gate: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !flags_r[CFS_IF] |=> !int_take_out)
    else $error("interrupt taken while disabled");

  chk_pe_sticky: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    wr_en && paddr_in == CFS_OFF_MSW && ctrl_r[CFS_PE] |=> ctrl_r[CFS_PE] && $stable(ctrl_r[31:4]))
    else $error("status word load cleared protection enable");

  chk_reserved_bits: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    ((flags_r & ~CFS_FLAGS_WMASK) == CFS_FLAGS_RESET) && ((ctrl_r & ~CFS_CTRL_WMASK) == 32'h0000_0000))
    else $error("reserved bit changed");

  chk_ext_fault: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    esc_op_in && ctrl_r[CFS_EM] |=> exc7_out)
    else $error("escape with emulate did not fault");

  chk_dir_step: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    str_step_in && str_size_in == CFS_SZ_DWORD
    |=> str_delta_out == ($past(flags_r[CFS_DF]) ? 32'hFFFF_FFFC : 32'h0000_0004))
    else $error("string step direction wrong");
endmodule
`default_nettype wire

// ===== sim/cpu_flags_control_state_bench.sv
// self-checking bench of the machine state block
`timescale 1ns/1ns
`default_nettype none
module cpu_flags_control_state_bench;
  import cfs_pkg::*;
  typedef struct packed {logic err; logic [31:0] d;} cfs_note_type;
  logic clk_sys_in = 0, resetn_in = 0;
  logic psel = 0, pen = 0, pwr = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, btgt = 32'h0;
  logic [31:0] prdata, fetch, gprd, flags, delta, maddr, mdata;
  logic pready, pslverr, pmode, pgon, v86, nest, itake, strap, dfault, e7, e13, iook, ifok;
  logic [15:0] lflags;
  logic [3:0] mben, rlen = 4'h0;
  cfs_alu_type alu = '0;
  cfs_gpr_type gpr = '0;
  cfs_store_type st = '0;
  logic [2:0] rd_idx = 3'h0;
  cfs_view_type rd_view = CFS_V_DWORD;
  cfs_size_type ssz = CFS_SZ_BYTE;
  logic ret = 0, br = 0, intr = 0, dhit = 0, io_op = 0, ifc_req = 0;
  logic priv = 0, wt = 0, coprocessor_escape_instruction = 0, stp = 0;
  logic [1:0] current_privilege_level = 2'h0;
  int failures = 0, n_checks = 0;
  cfs_note_type notes[$];
  cfs_note_type nt;

  cfs_machine_state i_dut (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .alu_in(alu), .gpr_wr_in(gpr), .gpr_rd_idx_in(rd_idx), .gpr_rd_view_in(rd_view),
    .store_in(st), .retire_in(ret), .retire_len_in(rlen), .branch_in(br),
    .branch_target_in(btgt), .intr_in(intr), .debug_hit_in(dhit), .cpl_in(current_privilege_level),
    .io_op_in(io_op), .if_change_in(ifc_req), .priv_op_in(priv), .wait_op_in(wt),
    .esc_op_in(coprocessor_escape_instruction), .str_step_in(stp), .str_size_in(ssz),
    .fetch_addr_out(fetch), .gpr_rd_data_out(gprd), .flags_out(flags),
    .legacy_flags_out(lflags), .protected_mode_out(pmode), .paging_on_out(pgon),
    .v86_mode_out(v86), .nested_task_out(nest), .int_take_out(itake), .step_trap_out(strap),
    .debug_fault_out(dfault), .exc7_out(e7), .exc13_out(e13), .io_direct_ok_out(iook),
    .if_change_ok_out(ifok), .str_delta_out(delta), .mem_addr_out(maddr),
    .mem_byte_en_out(mben), .mem_data_out(mdata));

  always #50 clk_sys_in = ~clk_sys_in;

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // read answers are judged here, in order of issue
  always @(posedge clk_sys_in) begin
    if (psel && pen && pready === 1'b1 && !pwr) begin
      nt = notes.pop_front();
      chk("prdata", prdata, nt.d);
      chk("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys_in);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    pen <= 1;
    // no wait limit here: only the watchdog ends a stuck access
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'b1);
    psel <= 0;
    pen <= 0;
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1, a, d);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] d, logic e = 0);
    notes.push_back({e, d});
    apb(0, a, 32'h0);
  endtask

  task automatic retire(logic [3:0] len, logic b, logic [31:0] t, logic q);
    @(posedge clk_sys_in);
    ret <= 1;
    rlen <= len;
    br <= b;
    btgt <= t;
    intr <= q;
    @(posedge clk_sys_in);
    ret <= 0;
    br <= 0;
    #1;
  endtask

  task automatic op(logic e, logic w, logic p);
    @(posedge clk_sys_in);
    coprocessor_escape_instruction <= e;
    wt <= w;
    priv <= p;
    @(posedge clk_sys_in);
    coprocessor_escape_instruction <= 0;
    wt <= 0;
    priv <= 0;
    #1;
  endtask

  task automatic gw(logic [2:0] x, cfs_view_type v, logic [31:0] d);
    @(posedge clk_sys_in);
    gpr <= '{1'b1, x, v, d};
    @(posedge clk_sys_in);
    gpr.we <= 0;
  endtask

  task automatic gr(logic [2:0] x, cfs_view_type v, logic [31:0] e);
    @(posedge clk_sys_in);
    rd_idx <= x;
    rd_view <= v;
    @(posedge clk_sys_in);
    #1;
    chk("gpr", gprd, e);
  endtask

  task automatic store(cfs_size_type z, logic [31:0] a, logic [31:0] d, logic [3:0] be);
    logic [31:0] m;
    for (int k = 0; k < 4; k++) m[8*k+:8] = {8{be[k]}};
    @(posedge clk_sys_in);
    st <= '{1'b1, z, a, d};
    @(posedge clk_sys_in);
    st.valid <= 0;
    #1;
    chk("maddr", maddr, a);
    chk("mben", {28'h0, mben}, {28'h0, be});
    chk("mdata", mdata & m, d & m);
  endtask

  // flag word expected from one add or subtract of the given width
  function automatic logic [31:0] exp_flags(logic s, cfs_size_type z, logic [31:0] a,
                                            logic [31:0] b);
    logic [32:0] r;
    logic [31:0] m, f;
    int w;
    w = z == CFS_SZ_BYTE ? 8 : (z == CFS_SZ_WORD ? 16 : 32);
    m = w == 32 ? 32'hFFFF_FFFF : (32'h1 << w) - 1;
    a = a & m;
    b = b & m;
    r = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    f = 32'h0000_0002;
    f[0] = r[w];
    f[2] = ~^r[7:0];
    f[4] = a[4] ^ b[4] ^ r[4];
    f[6] = (r[31:0] & m) == 0;
    f[7] = r[w-1];
    f[11] = (s ? a[w-1] != b[w-1] : a[w-1] == b[w-1]) && r[w-1] != a[w-1];
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic s;
    cfs_size_type z;
    logic [31:0] a, b;
    int n;
    void'($urandom(50583));
    repeat (3) @(posedge clk_sys_in);
    resetn_in <= 1;
    rd(8'h00, 32'h0000_0002);
    rd(8'h04, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h40, 32'h0, 1);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0003_7FD7);
    chk("flags", flags, 32'h0003_7FD7);
    chk("legacy", {16'h0, lflags}, 32'h0000_7FD7);
    chk("nest", nest, 1);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h8000_000F);
    rd(8'h10, 32'h0000_000F);
    chk("paging", pgon, 1);
    chk("v86", v86, 1);
    wr(8'h08, 32'h0);
    rd(8'h04, 32'h8000_0001);
    wr(8'h04, 32'h0);
    chk("pmode", pmode, 0);
    chk("paging", pgon, 0);
    wr(8'h08, 32'h0000_0001);
    chk("pmode", pmode, 1);
    // arithmetic flags, first pass is the carry-into-zero byte case
    wr(8'h00, 32'h0);
    for (int i = 0; i < 24; i++) begin
      s = i[0];
      z = cfs_size_type'(i % 3);
      a = i < 2 ? 32'h0000_00FF : $urandom;
      b = i < 2 ? 32'h0000_0001 : (i < 8 ? a : $urandom);
      @(posedge clk_sys_in);
      alu <= '{1'b1, s, z, a, b};
      @(posedge clk_sys_in);
      alu.valid <= 0;
      rd(8'h00, exp_flags(s, z, a, b));
    end
    wr(8'h0C, 32'h0000_0100);
    wr(8'h00, 32'h0000_0300);
    retire(4'd3, 0, 32'h0, 1);
    chk("int", itake, 1);
    chk("step", strap, 1);
    rd(8'h00, 32'h0000_0202);
    wr(8'h00, 32'h0001_0000);
    @(posedge clk_sys_in);
    dhit <= 1;
    retire(4'd2, 0, 32'h0, 1);
    chk("int", itake, 0);
    chk("dbg", dfault, 0);
    chk("fetch", fetch, 32'h0000_0105);
    retire(4'd1, 1, 32'h0000_4000, 0);
    chk("dbg", dfault, 1);
    chk("step", strap, 0);
    chk("fetch", fetch, 32'h0000_4000);
    // every combination of the three coprocessor bits
    for (int i = 0; i < 8; i++) begin
      wr(8'h04, {28'h0, i[2:0], 1'b0});
      op(1, 0, 0);
      chk("exc7", e7, i[1] | i[2]);
      op(0, 1, 0);
      chk("exc7", e7, i[0] & i[2]);
    end
    wr(8'h04, 32'h0000_0001);
    wr(8'h00, 32'h0002_0000);
    op(0, 0, 1);
    chk("exc13", e13, 1);
    wr(8'h04, 32'h0);
    op(0, 0, 1);
    chk("exc13", e13, 0);
    wr(8'h04, 32'h0000_0001);
    for (int i = 0; i < 32; i++) begin
      wr(8'h00, {14'h0, i[4], 3'h0, i[3:2], 12'h0});
      @(posedge clk_sys_in);
      current_privilege_level <= i[1:0];
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk("io", iook, !i[4] && i[1:0] <= i[3:2]);
      chk("ifc", ifok, !i[4] || i[1:0] <= i[3:2]);
    end
    wr(8'h04, 32'h0);
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk("io", iook, 1);
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, {21'h0, i[0], 10'h0});
      @(posedge clk_sys_in);
      stp <= 1;
      ssz <= cfs_size_type'(i / 2);
      @(posedge clk_sys_in);
      stp <= 0;
      #1;
      n = 1 << (i / 2);
      chk("delta", delta, i[0] ? -n : n);
    end
    gw(3'd1, CFS_V_DWORD, 32'h1122_3344);
    gw(3'd1, CFS_V_BYTE_HI, 32'h0000_00AA);
    gr(3'd1, CFS_V_DWORD, 32'h1122_AA44);
    gw(3'd1, CFS_V_WORD, 32'h0000_BEEF);
    gw(3'd1, CFS_V_BYTE_LO, 32'h0000_0077);
    gr(3'd1, CFS_V_WORD, 32'h0000_BE77);
    gr(3'd1, CFS_V_BYTE_HI, 32'h0000_00BE);
    gr(3'd1, CFS_V_BYTE_LO, 32'h0000_0077);
    // byte views above register 3 do not exist
    gw(3'd5, CFS_V_BYTE_LO, 32'h0000_00FF);
    gr(3'd5, CFS_V_DWORD, 32'h0);
    rd(8'h24, 32'h1122_BE77);
    store(CFS_SZ_DWORD, 32'h0000_1000, 32'hA1B2_C3D4, 4'hF);
    store(CFS_SZ_WORD, 32'h0000_2000, 32'h0000_5566, 4'h3);
    chk("notes", notes.size(), 32'h0);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
